// [agu_pkg.sv]
// Package with constants and carrier types for the bit-reverse and program-space address generator.
// =====================================================================
// What this block does
// [R1] Bit-reverse only on X write generator writes.
// [R2] Only modifier is reversed; addresses stay normal.
// [R3] Pointer select of 15 disables bit-reverse.
// [R4] Enable flag in modifier control bit 15.
// [R5] Software aligns 2^N byte buffer start.
// [R6] Pivot modifier is 15-bit low field.
// [R7] Pivot scaled to word byte addresses.
// [R8] Only pre/post increment word accesses reversed.
// [R9] New pointer is pointer plus scaled pivot.
// [R10] Reversed effective address LSB forced zero.
// [R11] Bit-reverse beats modulo on write generator.
// [R12] Software avoids modifier write then pointer read.
// [R13] Updates step in reversed-carry index order.
// [R14] Program space 24 bits, data 16 bits.
// [R15] Table address is page over 16-bit address.
// [R16] Table page bit 7 selects configuration memory.
// [R17] Remap address is page over 15 bits.
// [R18] Remap accesses reach user memory only.
// [R19] Remap window read-only, low word only.
// [R20] Table access reads and writes every byte.
// [R21] Remap only when core control bit 2 set.
// [R22] High table read upper data byte zero.
// [R23] Reversed carry runs from pivot MSB downward.
package agu_pkg;
  localparam int DW = 16;
  localparam int PW = 24;
  localparam int AW = 4;
  // Register indices on the plain register port.
  localparam logic [AW-1:0] REG_BITREV_MOD = 4'h0;
  localparam logic [AW-1:0] REG_ADDR_MODE  = 4'h1;
  localparam logic [AW-1:0] REG_TABLE_PAGE = 4'h2;
  localparam logic [AW-1:0] REG_REMAP_PAGE = 4'h3;
  localparam logic [AW-1:0] REG_CORE_CTRL  = 4'h4;
  localparam logic [AW-1:0] REG_STATUS     = 4'h5;
  // Field positions.
  localparam int BITREV_EN_BIT  = 15;
  localparam int PIVOT_W        = 15;
  localparam int PTR_SEL_LSB    = 8;
  localparam int PTR_SEL_W      = 4;
  localparam int XMOD_EN_BIT    = 15;
  localparam int XMOD_SEL_LSB   = 0;
  localparam int REMAP_EN_BIT   = 2;
  localparam int CFG_SEL_BIT    = 7;
  localparam int EA_MSB         = 15;
  localparam logic [PTR_SEL_W-1:0] PTR_SEL_OFF = 4'hf;
  // Reset values.
  localparam logic [DW-1:0] BITREV_MOD_RST = 16'h0000;
  localparam logic [DW-1:0] ADDR_MODE_RST  = 16'h0f0f;
  localparam logic [7:0]    PAGE_RST       = 8'h00;
  localparam logic [DW-1:0] CORE_CTRL_RST  = 16'h0000;

  typedef enum logic [2:0] {
    AM_DIRECT, AM_INDIRECT, AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC, AM_REG_OFS, AM_LIT_OFS
  } addr_mode_t;

  // Write address request from instruction decode.
  typedef struct packed {
    logic            valid;
    logic [3:0]      ptr_idx;
    addr_mode_t      mode;
    logic            byte_op;
    logic [DW-1:0]   ptr;
    logic [DW-1:0]   offset;
  } wr_req_t;

  typedef struct packed {
    logic            valid;
    logic [DW-1:0]   ea;
    logic [DW-1:0]   new_ptr;
    logic            bitrev;
    logic            modulo;
  } wr_ans_t;

  // Program-space request from data path.
  typedef struct packed {
    logic            valid;
    logic            table_op;
    logic            write;
    logic            high;
    logic            byte_op;
    logic [DW-1:0]   ea;
  } ps_req_t;

  typedef struct packed {
    logic            valid;
    logic [PW-1:0]   addr;
    logic            cfg_space;
    logic            write;
    logic            remap;
    logic            refused;
  } ps_ans_t;
endpackage

// [bitrev_and_progspace_agu.sv]
// Bit-reverse write address generator and program-space address former.
`timescale 1ns/1ps
`default_nettype none
module bitrev_and_progspace_agu (
  input  wire logic                     I_MCLK,
  input  wire logic                     I_RESETN,
  input  wire logic [agu_pkg::AW-1:0]   I_REG_ADDR,
  input  wire logic [agu_pkg::DW-1:0]   I_REG_WDATA,
  input  wire logic                     I_REG_WR,
  input  wire logic                     I_REG_RD,
  output logic      [agu_pkg::DW-1:0]   O_REG_RDATA,
  input  wire agu_pkg::wr_req_t         I_WR_REQ,
  output agu_pkg::wr_ans_t              O_WR_ANS,
  input  wire agu_pkg::ps_req_t         I_PS_REQ,
  input  wire logic [agu_pkg::PW-1:0]   I_PS_WORD,
  output agu_pkg::ps_ans_t              O_PS_ANS,
  output logic      [agu_pkg::DW-1:0]   O_PS_RDATA
);
  import agu_pkg::*;

  // =====================================================================
  // Registers
  logic [DW-1:0] bitrev_mod_q;
  logic [DW-1:0] addr_mode_q;
  logic [7:0]    table_page_q;
  logic [7:0]    remap_page_q;
  logic [DW-1:0] core_ctrl_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] bitrev_cnt_q;

  // Register write decode.
  wire wr_brev  = I_REG_WR && (I_REG_ADDR == REG_BITREV_MOD);
  wire wr_amode = I_REG_WR && (I_REG_ADDR == REG_ADDR_MODE);
  wire wr_tpage = I_REG_WR && (I_REG_ADDR == REG_TABLE_PAGE);
  wire wr_rpage = I_REG_WR && (I_REG_ADDR == REG_REMAP_PAGE);
  wire wr_core  = I_REG_WR && (I_REG_ADDR == REG_CORE_CTRL);

  // Register read selection; unmapped addresses read zero.
  logic [DW-1:0] rd_mux;
  assign rd_mux = (I_REG_ADDR == REG_BITREV_MOD) ? bitrev_mod_q :
                  (I_REG_ADDR == REG_ADDR_MODE)  ? addr_mode_q :
                  (I_REG_ADDR == REG_TABLE_PAGE) ? {8'h00, table_page_q} :
                  (I_REG_ADDR == REG_REMAP_PAGE) ? {8'h00, remap_page_q} :
                  (I_REG_ADDR == REG_CORE_CTRL)  ? core_ctrl_q :
                  (I_REG_ADDR == REG_STATUS)     ? bitrev_cnt_q : 16'h0000;

  // =====================================================================
  // Bit-reverse enable and write address generation
  wire [PTR_SEL_W-1:0] ptr_sel  = addr_mode_q[PTR_SEL_LSB +: PTR_SEL_W];
  wire [PTR_SEL_W-1:0] xmod_sel = addr_mode_q[XMOD_SEL_LSB +: PTR_SEL_W];
  wire brev_armed = (ptr_sel != PTR_SEL_OFF)                 // [R3]
                 && bitrev_mod_q[BITREV_EN_BIT];             // [R4]
  wire inc_mode  = (I_WR_REQ.mode == AM_PRE_INC) || (I_WR_REQ.mode == AM_POST_INC);
  // Only word writes through the selected pointer in an increment mode are reversed.
  wire brev_act  = I_WR_REQ.valid && brev_armed && inc_mode && !I_WR_REQ.byte_op
                && (I_WR_REQ.ptr_idx == ptr_sel);            // [R1] [R8]
  // Modulo on the write generator yields to bit-reverse.
  wire mod_act   = I_WR_REQ.valid && addr_mode_q[XMOD_EN_BIT] && (xmod_sel != PTR_SEL_OFF)
                && (I_WR_REQ.ptr_idx == xmod_sel) && !brev_act; // [R11]

  // Pivot scaled by two so it steps word-aligned byte addresses.
  wire [DW-1:0] pivot_scaled = {bitrev_mod_q[PIVOT_W-1:0], 1'b0}; // [R6] [R7]

  // Reverse-carry add: reverse both operands, add normally, reverse back.
  function automatic logic [DW-1:0] rev16(input logic [DW-1:0] v);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++) begin
      r[i] = v[DW-1-i];
    end
    return r;
  endfunction

  // Carries flow from the pivot MSB downward; bits above the pivot's top bit stay put.
  logic [DW-1:0] hi_mask;
  always_comb begin
    hi_mask = '1;
    for (int i = 0; i < DW; i++) begin
      if (pivot_scaled[i]) begin
        hi_mask = ~((16'h0002 << i) - 16'h0001);
      end
    end
  end
  wire [DW-1:0] rc_sum  = rev16(rev16(I_WR_REQ.ptr) + rev16(pivot_scaled)); // [R2] [R9] [R13] [R23]
  wire [DW-1:0] brev_np = ((I_WR_REQ.ptr & hi_mask) | (rc_sum & ~hi_mask)) & 16'hfffe; // [R10]

  // Normal next pointer; the offset carries the signed step or index.
  wire [DW-1:0] norm_np = (I_WR_REQ.mode == AM_POST_INC || I_WR_REQ.mode == AM_PRE_INC) ?
                          I_WR_REQ.ptr + I_WR_REQ.offset :
                          (I_WR_REQ.mode == AM_POST_DEC || I_WR_REQ.mode == AM_PRE_DEC) ?
                          I_WR_REQ.ptr - I_WR_REQ.offset : I_WR_REQ.ptr;
  wire pre_mode = (I_WR_REQ.mode == AM_PRE_INC) || (I_WR_REQ.mode == AM_PRE_DEC);
  wire ofs_mode = (I_WR_REQ.mode == AM_REG_OFS) || (I_WR_REQ.mode == AM_LIT_OFS);
  wire [DW-1:0] norm_ea = pre_mode ? norm_np :
                          ofs_mode ? I_WR_REQ.ptr + I_WR_REQ.offset : I_WR_REQ.ptr;
  // Effective address: the pointer with bit 0 cleared in post mode, the updated one in pre mode.
  wire [DW-1:0] brev_ea = (I_WR_REQ.mode == AM_PRE_INC) ? brev_np : (I_WR_REQ.ptr & 16'hfffe); // [R10]

  wr_ans_t wr_d;
  assign wr_d.valid   = I_WR_REQ.valid;
  assign wr_d.ea      = brev_act ? brev_ea : norm_ea;
  assign wr_d.new_ptr = brev_act ? brev_np : norm_np; // [R9]
  assign wr_d.bitrev  = brev_act;
  assign wr_d.modulo  = mod_act;                      // [R11]

  // =====================================================================
  // Program-space address formation
  wire remap_hit = I_PS_REQ.valid && !I_PS_REQ.table_op && I_PS_REQ.ea[EA_MSB]
                && core_ctrl_q[REMAP_EN_BIT];         // [R21]
  wire remap_bad = remap_hit && I_PS_REQ.write;       // [R19]
  ps_ans_t ps_d;
  assign ps_d.valid     = I_PS_REQ.valid && (I_PS_REQ.table_op || remap_hit);
  // Table: page over full EA; remap: zero, page, then low 15 bits of EA.
  assign ps_d.addr      = I_PS_REQ.table_op ? {table_page_q, I_PS_REQ.ea} :      // [R14] [R15]
                          {1'b0, remap_page_q, I_PS_REQ.ea[EA_MSB-1:0]};        // [R17] [R18]
  assign ps_d.cfg_space = I_PS_REQ.table_op && table_page_q[CFG_SEL_BIT];       // [R16]
  assign ps_d.write     = I_PS_REQ.table_op && I_PS_REQ.write;                  // [R20]
  assign ps_d.remap     = remap_hit && !remap_bad;
  assign ps_d.refused   = remap_bad;

  // Read data steering from the fetched program word.
  wire [7:0] lo_byte = I_PS_REQ.ea[0] ? I_PS_WORD[15:8] : I_PS_WORD[7:0];
  wire [7:0] hi_byte = I_PS_REQ.ea[0] ? 8'h00 : I_PS_WORD[23:16];               // [R22]
  wire [DW-1:0] ps_rd = !I_PS_REQ.table_op ? I_PS_WORD[DW-1:0] :                // [R19]
                        (I_PS_REQ.high && I_PS_REQ.byte_op) ? {8'h00, hi_byte} :
                        I_PS_REQ.high ? {8'h00, I_PS_WORD[23:16]} :            // [R22]
                        I_PS_REQ.byte_op ? {8'h00, lo_byte} : I_PS_WORD[DW-1:0]; // [R20]

  // =====================================================================
  // Register storage.
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bitrev_mod_q <= BITREV_MOD_RST;
      addr_mode_q  <= ADDR_MODE_RST;
      table_page_q <= PAGE_RST;
      remap_page_q <= PAGE_RST;
      core_ctrl_q  <= CORE_CTRL_RST;
    end else begin
      if (wr_brev)  bitrev_mod_q <= I_REG_WDATA;
      if (wr_amode) addr_mode_q  <= I_REG_WDATA;
      if (wr_tpage) table_page_q <= I_REG_WDATA[7:0];
      if (wr_rpage) remap_page_q <= I_REG_WDATA[7:0];
      if (wr_core)  core_ctrl_q  <= I_REG_WDATA;
    end
  end

  // Read data and count of reversed writes.
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_q      <= '0;
      bitrev_cnt_q <= '0;
    end else begin
      rdata_q      <= I_REG_RD ? rd_mux : 16'h0000;
      bitrev_cnt_q <= bitrev_cnt_q + {15'h0000, brev_act};
    end
  end

  // Registered answers.
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_WR_ANS   <= '0;
      O_PS_ANS   <= '0;
      O_PS_RDATA <= '0;
    end else begin
      O_WR_ANS   <= wr_d;
      O_PS_ANS   <= ps_d;
      O_PS_RDATA <= ps_rd;
    end
  end
  assign O_REG_RDATA = rdata_q;

  // =====================================================================
  // Checks
  a_stack_never_rev: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R3]
    (ptr_sel == PTR_SEL_OFF) |=> !O_WR_ANS.bitrev) else $error("bit-reverse with pointer select 15");
  a_enable_needed: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R4]
    !bitrev_mod_q[BITREV_EN_BIT] |=> !O_WR_ANS.bitrev) else $error("bit-reverse without enable");
  a_byte_normal: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R8]
    I_WR_REQ.byte_op |=> !O_WR_ANS.bitrev) else $error("byte access reversed");
  a_rev_lsb_zero: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R10]
    O_WR_ANS.bitrev |-> (O_WR_ANS.ea[0] == 1'b0 && O_WR_ANS.new_ptr[0] == 1'b0)) else $error("reversed lsb set");
  a_rev_beats_mod: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R11]
    O_WR_ANS.bitrev |-> !O_WR_ANS.modulo) else $error("modulo with bit-reverse");
  a_table_addr: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R15]
    (I_PS_REQ.valid && I_PS_REQ.table_op) |=> O_PS_ANS.addr == {$past(table_page_q), $past(I_PS_REQ.ea)})
    else $error("table address wrong");
  a_remap_user: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R18]
    O_PS_ANS.remap |-> (!O_PS_ANS.cfg_space && !O_PS_ANS.addr[PW-1])) else $error("remap outside user memory");
  a_remap_gated: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R21]
    !core_ctrl_q[REMAP_EN_BIT] |=> !O_PS_ANS.remap) else $error("remap while disabled");
  a_phantom_zero: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R22]
    (I_PS_REQ.valid && I_PS_REQ.table_op && I_PS_REQ.high) |=> O_PS_RDATA[15:8] == 8'h00)
    else $error("phantom byte not zero");

  // =====================================================================
  // Remap window, table page and bit-reverse request checks
  // A remap read request: data-space access above the window base with remap on.
  sequence s_remap_read_req;
    I_PS_REQ.valid && !I_PS_REQ.table_op && !I_PS_REQ.write
    && I_PS_REQ.ea[EA_MSB] && core_ctrl_q[REMAP_EN_BIT];
  endsequence
  // The answer one cycle on: page over the low fifteen bits, top bit clear.
  sequence s_remap_answer;
    ##1 (O_PS_ANS.remap && O_PS_ANS.valid && !O_PS_ANS.addr[PW-1]
         && O_PS_ANS.addr[PW-2:EA_MSB] == $past(remap_page_q)
         && O_PS_ANS.addr[EA_MSB-1:0] == $past(I_PS_REQ.ea[EA_MSB-1:0]));
  endsequence
  a_remap_addr: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R17]
    s_remap_read_req |-> s_remap_answer) else $error("remap address wrong");
  a_remap_no_write: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R19]
    O_PS_ANS.remap |-> !O_PS_ANS.write) else $error("write through remap window");
  a_cfg_select: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R16]
    (I_PS_REQ.valid && I_PS_REQ.table_op) |=> O_PS_ANS.cfg_space == $past(table_page_q[CFG_SEL_BIT]))
    else $error("table memory select wrong");
  a_rev_needs_req: assert property (@(posedge I_MCLK) disable iff (!I_RESETN) // [R1]
    O_WR_ANS.bitrev |-> O_WR_ANS.valid) else $error("bit-reverse without a write request");
endmodule
`default_nettype wire

// [prog_mem_model.sv]
// Program memory model feeding 24-bit words to the address former.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic             i_clk,
  input  wire agu_pkg::ps_req_t i_req,
  output logic [23:0]           o_word
);
  import agu_pkg::*;
  // Seeded so that idle cycles show a defined, changing pattern.
  logic [23:0] last_q = 24'h5a3c96;
  // A fetch returns a word built from its address; idle cycles show a changing pattern.
  assign o_word = i_req.valid ? {i_req.ea[7:0] ^ 8'h3c, ~i_req.ea} : ~last_q;
  always_ff @(posedge i_clk) begin
    last_q <= o_word;
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the bit-reverse and program-space address generator.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import agu_pkg::*;
  logic          I_MCLK = 1'b0, I_RESETN = 1'b0, I_REG_WR = 1'b0, I_REG_RD = 1'b0;
  logic [AW-1:0] I_REG_ADDR = '0;
  logic [DW-1:0] I_REG_WDATA = '0, O_REG_RDATA, O_PS_RDATA, modc, amode, core, pd;
  logic [PW-1:0] I_PS_WORD;
  logic [7:0]    tpg, rpg;
  logic [63:0]   rv;
  wr_req_t       I_WR_REQ = '0, q;
  wr_ans_t       O_WR_ANS, pw;
  ps_req_t       I_PS_REQ = '0;
  ps_ans_t       O_PS_ANS, pp;
  int            fails = 0, n_checks = 0, seed = 32'h7f7a3f85, nbr = 0;
  logic [15:0]   rst [6] = '{BITREV_MOD_RST, ADDR_MODE_RST, {8'h0, PAGE_RST}, {8'h0, PAGE_RST}, CORE_CTRL_RST, 16'h0};
  // Clock of 25 ns.
  always #12.5 I_MCLK = ~I_MCLK;
  bitrev_and_progspace_agu DUT (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .I_WR_REQ(I_WR_REQ), .O_WR_ANS(O_WR_ANS), .I_PS_REQ(I_PS_REQ), .I_PS_WORD(I_PS_WORD),
    .O_PS_ANS(O_PS_ANS), .O_PS_RDATA(O_PS_RDATA));
  prog_mem_model mem (.i_clk(I_MCLK), .i_req(I_PS_REQ), .o_word(I_PS_WORD));
  task automatic check(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge I_MCLK);
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    I_REG_WR <= 1'b1;
    @(posedge I_MCLK);
    I_REG_WR <= 1'b0;
  endtask
  task automatic rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge I_MCLK);
    I_REG_ADDR <= a;
    I_REG_RD <= 1'b1;
    @(posedge I_MCLK);
    I_REG_RD <= 1'b0;
    #1 check("reg read", e, O_REG_RDATA);
  endtask
  // Reference answer of the write generator, carries running downward from the pivot top bit.
  function automatic wr_ans_t wexp(input wr_req_t r);
    logic [15:0] p, s;
    logic c;
    int k;
    wexp = '0;
    wexp.valid = r.valid;
    p = {modc[14:0], 1'b0};
    wexp.bitrev = r.valid && modc[15] && amode[11:8] != 4'hf && r.ptr_idx == amode[11:8] && !r.byte_op
                  && (r.mode == AM_PRE_INC || r.mode == AM_POST_INC);
    s = r.ptr;
    c = 1'b0;
    k = 15;
    while (k > 0 && !p[k]) k--;
    for (int i = k; i >= 0; i--) {c, s[i]} = {1'b0, r.ptr[i]} + p[i] + c;
    s[0] = 1'b0;
    wexp.new_ptr = s;
    wexp.ea = r.mode == AM_PRE_INC ? s : {r.ptr[15:1], 1'b0};
    if (!wexp.bitrev) begin
      case (r.mode)
        AM_POST_INC, AM_PRE_INC: s = r.ptr + r.offset;
        AM_POST_DEC, AM_PRE_DEC: s = r.ptr - r.offset;
        default: s = r.ptr;
      endcase
      wexp.new_ptr = s;
      wexp.ea = (r.mode == AM_PRE_INC || r.mode == AM_PRE_DEC) ? s
              : (r.mode == AM_REG_OFS || r.mode == AM_LIT_OFS) ? r.ptr + r.offset : r.ptr;
    end
  endfunction
  // Drives one request pair and compares the answers to the previous pair.
  task automatic step(input wr_req_t w, input ps_req_t r);
    @(posedge I_MCLK);
    I_WR_REQ <= w;
    I_PS_REQ <= r;
    #1 check("wr valid", pw.valid, O_WR_ANS.valid);
    if (pw.valid) check("bitrev", pw.bitrev, O_WR_ANS.bitrev);
    if (pw.valid) check("wr ea", {pw.ea, pw.new_ptr}, {O_WR_ANS.ea, O_WR_ANS.new_ptr});
    if (pw.bitrev) check("modulo", 0, O_WR_ANS.modulo);
    check("ps valid", pp.valid, O_PS_ANS.valid);
    if (pp.valid) check("ps flags", {pp.refused, pp.remap}, {O_PS_ANS.refused, O_PS_ANS.remap});
    if (pp.valid && !pp.refused) check("ps addr", {pp.cfg_space, pp.write, pp.addr},
      {O_PS_ANS.cfg_space, O_PS_ANS.write, O_PS_ANS.addr});
    if (pp.valid && !pp.write) check("ps rdata", pd, O_PS_RDATA);
    pw = wexp(w);
    nbr += pw.bitrev;
    pp = '0;
    pd = '0;
    if (r.valid && r.table_op) begin
      pp = '{1'b1, {tpg, r.ea}, tpg[7], r.write, 1'b0, 1'b0};
      pd = r.high ? {8'h0, (r.byte_op && r.ea[0]) ? 8'h0 : I_PS_WORD[23:16]} : !r.byte_op ? I_PS_WORD[15:0]
           : {8'h0, r.ea[0] ? I_PS_WORD[15:8] : I_PS_WORD[7:0]};
    end else if (r.valid && r.ea[15] && core[REMAP_EN_BIT]) begin
      pp = r.write ? ps_ans_t'{1'b1, 24'h0, 1'b0, 1'b1, 1'b0, 1'b1}
                   : ps_ans_t'{1'b1, {1'b0, rpg, r.ea[14:0]}, 1'b0, 1'b0, 1'b1, 1'b0};
      pd = I_PS_WORD[15:0];
    end
  endtask
  task automatic setup(input logic [DW-1:0] m, a, c, input logic [7:0] t, r);
    {modc, amode, core, tpg, rpg} = {m, a, c, t, r};
    wreg(REG_BITREV_MOD, m);
    wreg(REG_ADDR_MODE, a);
    wreg(REG_CORE_CTRL, c);
    wreg(REG_TABLE_PAGE, {8'h0, t});
    wreg(REG_REMAP_PAGE, {8'h0, r});
    rreg(REG_BITREV_MOD, m);
    rreg(REG_TABLE_PAGE, {8'h0, t});
    rreg(REG_REMAP_PAGE, {8'h0, r});
  endtask
  // Watchdog cuts a hang short.
  initial begin
    #(25 * 20000);
    fails++;
    tally_and_finish();
  end
  // Main sequence: reset values, reversed-carry walk, then random traffic.
  initial begin
    {pw, pp, pd} = '0;
    repeat (10) @(posedge I_MCLK);
    I_RESETN <= 1'b1;
    for (int i = 0; i < 6; i++) rreg(i[3:0], rst[i]);
    wreg(4'h9, 16'hffff);
    rreg(4'h9, 16'h0);
    setup(16'h8008, 16'h8303, 16'h0, 8'h0, 8'h0);
    q = '{1'b1, 4'h3, AM_POST_INC, 1'b0, 16'h2000, 16'h2};
    for (logic [4:0] k = 0; k <= 16; k++) begin
      q.ptr = 16'h2000 + {11'h0, k[0], k[1], k[2], k[3], 1'b0};
      step(q, '0);
      if (k > 0) check("walk", q.ptr, O_WR_ANS.new_ptr);
    end
    for (int r = 0; r < 4; r++) begin
      step('0, '0);
      rv = {$random(seed), $random(seed)};
      setup({r[1], rv[14:0]}, {rv[15], 3'h0, rv[19:16], 4'h0, rv[19:16]}, {13'h0, r[0], 2'h0}, rv[47:40], rv[55:48]);
      repeat (200) begin
        rv = {$random(seed), $random(seed)};
        q = rv[40:0];
        q.valid = rv[62] | rv[61];
        if (rv[63]) q.ptr_idx = amode[11:8];
        step(q, rv[60:40]);
      end
    end
    step('0, '0);
    rreg(REG_STATUS, nbr[15:0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
